// ---- core/psfclc_ctl_if.sv ----
// Carrier between the register bank and its measurement and timer helpers
// Assumes all members live on the oscillator clock
`timescale 1ns/1ps
interface psfclc_ctl_if;
    logic                          meas_start;
    logic [7:0]                    meas_len;
    logic [7:0]                    meas_count;
    logic [psfclc_pkg::TMO_W-1:0]  tmo_cycles;
    logic                          link_detect;

    modport regs  (output meas_start, meas_len, tmo_cycles,
                   input meas_count, link_detect);
    modport meter (input meas_start, meas_len, output meas_count);
    modport timer (input tmo_cycles, output link_detect);
endinterface : psfclc_ctl_if

// ---- core/psfclc_freq_meter.sv ----
// Pixel clock edge counter over a gated interval of oscillator cycles
// Assumes pix_clk_i is asynchronous and slower than half the oscillator rate
`timescale 1ns/1ps
module psfclc_freq_meter (
    input  wire logic   clock_i,
    input  wire logic   rst_i,
    input  wire logic   pix_clk_i,
    psfclc_ctl_if.meter ctl
);
    import psfclc_pkg::*;

    logic [2:0]      pix_sync_ff;
    logic [2:0]      nxt_pix_sync;
    psfclc_meas_st_t state_ff;
    psfclc_meas_st_t nxt_state;
    logic [7:0]      remain_ff;
    logic [7:0]      nxt_remain;
    logic [7:0]      count_ff;
    logic [7:0]      nxt_count;
    logic            pix_edge;

    // Stage 0 feeds stage 1 only; edge taken from stages 1 and 2
    assign nxt_pix_sync = {pix_sync_ff[1:0], pix_clk_i}; // RL21
    assign pix_edge     = pix_sync_ff[1] & ~pix_sync_ff[2];

    always_comb begin
        nxt_state  = state_ff;
        nxt_remain = remain_ff;
        nxt_count  = count_ff;
        if (ctl.meas_start) begin
            nxt_count  = 8'h00; // RL21
            nxt_remain = ctl.meas_len; // RL10
            nxt_state  = (ctl.meas_len != 8'h00) ? PSFCLC_MEAS_RUN : PSFCLC_MEAS_IDLE; // RL9
        end else begin
            case (state_ff)
                PSFCLC_MEAS_RUN: begin
                    if (pix_edge && (count_ff != 8'hFF)) begin
                        nxt_count = 8'(count_ff + 8'h01); // RL12
                    end
                    nxt_remain = 8'(remain_ff - 8'h01);
                    if (remain_ff == 8'h01) begin
                        nxt_state = PSFCLC_MEAS_IDLE; // RL10
                    end
                end
                PSFCLC_MEAS_IDLE: begin
                    nxt_state = PSFCLC_MEAS_IDLE;
                end
                default: begin
                    nxt_state = PSFCLC_MEAS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pix_sync_ff <= RST_PIX_SYNC;
            state_ff    <= PSFCLC_MEAS_IDLE;
            remain_ff   <= RST_PIX_RATE;
            count_ff    <= RST_PIX_RATE;
        end else begin
            pix_sync_ff <= nxt_pix_sync;
            state_ff    <= nxt_state;
            remain_ff   <= nxt_remain;
            count_ff    <= nxt_count;
        end
    end

    assign ctl.meas_count = count_ff; // RL11

endmodule : psfclc_freq_meter

// ---- core/psfclc_link_timer.sv ----
// Link detect timer restarted by valid reverse-channel traffic
// Assumes rev_valid_i is a one-cycle pulse on the oscillator clock
`timescale 1ns/1ps
module psfclc_link_timer (
    input  wire logic   clock_i,
    input  wire logic   rst_i,
    input  wire logic   rev_valid_i,
    psfclc_ctl_if.timer ctl
);
    import psfclc_pkg::*;

    logic [TMO_W-1:0] left_ff;
    logic [TMO_W-1:0] nxt_left;
    logic             detect_ff;
    logic             nxt_detect;

    always_comb begin
        nxt_left   = left_ff;
        nxt_detect = detect_ff;
        if (rev_valid_i) begin
            nxt_left   = ctl.tmo_cycles; // RL22
            nxt_detect = 1'b1;
        end else if (detect_ff) begin
            if (left_ff <= 15'h0001) begin
                nxt_left   = RST_TMO_LEFT;
                nxt_detect = 1'b0; // RL19
            end else begin
                nxt_left = TMO_W'(left_ff - 15'h0001); // RL22
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            left_ff   <= RST_TMO_LEFT;
            detect_ff <= 1'b0;
        end else begin
            left_ff   <= nxt_left;
            detect_ff <= nxt_detect;
        end
    end

    assign ctl.link_detect = detect_ff;

endmodule : psfclc_link_timer

// ---- core/psfclc_pkg.sv ----
// Shared constants for the port steering, pixel rate and link timeout registers
// Assumes a single 20 MHz oscillator clock domain
package psfclc_pkg;

    localparam logic [7:0] OFS_PORT_STEER   = 8'h1E;
    localparam logic [7:0] OFS_PIX_RATE     = 8'h1F;
    localparam logic [7:0] OFS_CAPS         = 8'h20;
    localparam logic [7:0] OFS_CAPS2        = 8'h21;
    localparam logic [7:0] OFS_LINK_TMO     = 8'h26;

    localparam logic [7:0] RST_PORT_STEER   = 8'h01;
    localparam logic [7:0] RST_PIX_RATE     = 8'h00;
    localparam logic [7:0] RST_CAPS         = 8'h00;
    localparam logic [7:0] RST_CAPS2        = 8'h00;
    localparam logic [7:0] RST_LINK_TMO     = 8'h00;

    localparam logic [7:0] PORT_STEER_MASK  = 8'h07;
    localparam logic [7:0] CAPS_MASK        = 8'hBF;
    localparam logic [7:0] AUTO_CAPS_MASK   = 8'h0F;
    localparam logic [7:0] LINK_TMO_MASK    = 8'h03;

    localparam int BIT_SEC_ADDR_EN  = 2;
    localparam int BIT_SECOND_PORT  = 1;
    localparam int BIT_FIRST_PORT   = 0;
    localparam int BIT_HOLD_CAPS    = 7;
    localparam int BIT_RATE_TRAIN   = 5;
    localparam int BIT_EQ_TRAIN     = 4;

    localparam int CLK_MHZ          = 20;
    localparam int TMO_162_NS       = 162000;
    localparam int TMO_325_NS       = 325000;
    localparam int TMO_650_NS       = 650000;
    localparam int TMO_1300_NS      = 1300000;
    localparam int TMO_162_CYC      = (TMO_162_NS * CLK_MHZ + 999) / 1000;
    localparam int TMO_325_CYC      = (TMO_325_NS * CLK_MHZ + 999) / 1000;
    localparam int TMO_650_CYC      = (TMO_650_NS * CLK_MHZ + 999) / 1000;
    localparam int TMO_1300_CYC     = (TMO_1300_NS * CLK_MHZ + 999) / 1000;
    localparam int TMO_W            = 15;

    localparam logic [TMO_W-1:0] RST_TMO_LEFT = 15'h0000;
    localparam logic [2:0]       RST_PIX_SYNC = 3'h0;

    typedef enum logic [1:0] {
        PSFCLC_TMO_325  = 2'b00,
        PSFCLC_TMO_162  = 2'b01,
        PSFCLC_TMO_650  = 2'b10,
        PSFCLC_TMO_1300 = 2'b11
    } psfclc_tmo_sel_t;

    typedef enum logic {
        PSFCLC_MEAS_IDLE = 1'b0,
        PSFCLC_MEAS_RUN  = 1'b1
    } psfclc_meas_st_t;

endpackage : psfclc_pkg

// ---- core/psfclc_port_regs.sv ----
// Port steering, pixel rate measurement, remote caps and link timeout registers
// Assumes the serial control bus slave decodes frames and presents one access per strobe
//
// What this block does
// RL1: Second address is primary address plus one
// RL2: Second address reaches port one and shared
// RL3: Host enables second address before mirrored remote access
// RL4: Port one steer writes and reads port one
// RL5: Port zero steer writes and reads port zero
// RL6: Both steers set reads port one
// RL7: Port one steer moves low I/O control
// RL8: Steer bits ignored while second address enabled
// RL9: Writing rate register starts edge count
// RL10: Interval equals written value times clock period
// RL11: Reading rate register returns latest count
// RL12: Edge count saturates at all ones
// RL13: Freeze bit stops caps auto loading
// RL14: Training bits send rate or equalizer patterns
// RL15: Caps bit shows dual link receiver
// RL16: Caps bit shows receiver channel number
// RL17: Four caps bits auto loaded after lock
// RL18: Software overwriting caps also sets freeze; here freeze is set only if the written value has bit 7 set
// RL19: Link detect drops when timer expires
// RL20: Two bit field selects four timeouts
// RL21: Pixel edges synchronised, count restarts on write
// RL22: Timer restarts on valid reverse traffic
`timescale 1ns/1ps
module psfclc_port_regs #(
    parameter logic [6:0] PRIMARY_ADDR = 7'h2C, // Arbitrary value
    parameter int         TMO_325_CYC  = psfclc_pkg::TMO_325_CYC,
    parameter int         TMO_650_CYC  = psfclc_pkg::TMO_650_CYC,
    parameter int         TMO_1300_CYC = psfclc_pkg::TMO_1300_CYC
) (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic [6:0] bus_dev_addr_i,
    input  wire logic [7:0] bus_offset_i,
    input  wire logic       bus_wr_i,
    input  wire logic       bus_rd_i,
    input  wire logic [7:0] bus_wdata_i,
    output logic            bus_ack_o,
    output logic [7:0]      bus_rdata_o,
    input  wire logic       pix_clk_i,
    input  wire logic       rev_valid_i,
    output logic            link_detect_o,
    input  wire logic [1:0] caps_load_i,
    input  wire logic [3:0] caps_auto_p0_i,
    input  wire logic [3:0] caps_auto_p1_i,
    output logic [1:0]      rate_training_tx_o,
    output logic [1:0]      equalizer_training_tx_o,
    output logic            io_ctrl_second_link_o
);
    import psfclc_pkg::*;

    localparam logic [6:0] SECONDARY_ADDR = 7'(PRIMARY_ADDR + 7'h01);
    localparam int         TMO_MAX        = (1 << TMO_W) - 1;

    generate
        if (PRIMARY_ADDR == 7'h7F) begin : g_bad_addr
            $error("Primary address leaves no room for the second address");
        end
        if ((TMO_325_CYC < 1) || (TMO_325_CYC > TMO_MAX) ||
            (TMO_650_CYC < 1) || (TMO_650_CYC > TMO_MAX) ||
            (TMO_1300_CYC < 1) || (TMO_1300_CYC > TMO_MAX)) begin : g_bad_tmo
            $error("Timeout counts must fit the timer width");
        end
    endgenerate

    psfclc_ctl_if ctl ();

    logic [2:0] steer_ff;
    logic [2:0] nxt_steer;
    logic [1:0] tmo_ff;
    logic [1:0] nxt_tmo;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [7:0] caps_ff   [2];
    logic [7:0] nxt_caps  [2];
    logic [7:0] caps2_ff  [2];
    logic [7:0] nxt_caps2 [2];
    logic [3:0] caps_auto [2];

    logic       pri_hit;
    logic       sec_hit;
    logic       steer_live;
    logic       dev_hit;
    logic       wr_shared;
    logic [1:0] wr_port;
    logic       rd_second;

    assign caps_auto[0] = caps_auto_p0_i;
    assign caps_auto[1] = caps_auto_p1_i;

    // Device address decode
    assign pri_hit    = (bus_dev_addr_i == PRIMARY_ADDR);
    assign sec_hit    = steer_ff[BIT_SEC_ADDR_EN] && (bus_dev_addr_i == SECONDARY_ADDR); // RL1
    assign steer_live = pri_hit && !steer_ff[BIT_SEC_ADDR_EN]; // RL8
    assign dev_hit    = pri_hit || sec_hit;
    assign bus_ack_o  = dev_hit && (bus_wr_i || bus_rd_i);
    assign wr_shared  = dev_hit && bus_wr_i; // RL2

    // Per-port write and read steering
    always_comb begin
        wr_port   = 2'b00;
        rd_second = 1'b0;
        if (sec_hit) begin
            wr_port[1] = bus_wr_i; // RL2
            rd_second  = 1'b1; // RL2
        end else if (pri_hit && !steer_live) begin
            wr_port[0] = bus_wr_i; // RL8
        end else if (steer_live) begin
            wr_port[1] = bus_wr_i && steer_ff[BIT_SECOND_PORT]; // RL4
            wr_port[0] = bus_wr_i && steer_ff[BIT_FIRST_PORT]; // RL5
            rd_second  = steer_ff[BIT_SECOND_PORT]; // RL6
        end
    end

    assign io_ctrl_second_link_o = steer_ff[BIT_SECOND_PORT] &&
                                   !steer_ff[BIT_SEC_ADDR_EN]; // RL7

    // Shared registers
    always_comb begin
        nxt_steer = steer_ff;
        nxt_tmo   = tmo_ff;
        if (wr_shared && (bus_offset_i == OFS_PORT_STEER)) begin
            nxt_steer = bus_wdata_i[2:0] & PORT_STEER_MASK[2:0];
        end
        if (wr_shared && (bus_offset_i == OFS_LINK_TMO)) begin
            nxt_tmo = bus_wdata_i[1:0] & LINK_TMO_MASK[1:0]; // RL20
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            steer_ff <= RST_PORT_STEER[2:0];
            tmo_ff   <= RST_LINK_TMO[1:0];
        end else begin
            steer_ff <= nxt_steer;
            tmo_ff   <= nxt_tmo;
        end
    end

    // Measurement start travels with the written interval length
    assign ctl.meas_start = wr_shared && (bus_offset_i == OFS_PIX_RATE); // RL9
    assign ctl.meas_len   = bus_wdata_i; // RL10

    // Timeout selection
    always_comb begin
        case (psfclc_tmo_sel_t'(tmo_ff))
            PSFCLC_TMO_325:  ctl.tmo_cycles = TMO_W'(TMO_325_CYC); // RL20
            PSFCLC_TMO_162:  ctl.tmo_cycles = TMO_W'(TMO_162_CYC); // RL20
            PSFCLC_TMO_650:  ctl.tmo_cycles = TMO_W'(TMO_650_CYC); // RL20
            PSFCLC_TMO_1300: ctl.tmo_cycles = TMO_W'(TMO_1300_CYC); // RL20
            default:         ctl.tmo_cycles = TMO_W'(TMO_325_CYC);
        endcase
    end

    assign link_detect_o = ctl.link_detect; // RL19

    // Remote receiver capability registers, one copy per port
    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            always_comb begin
                nxt_caps[p]  = caps_ff[p];
                nxt_caps2[p] = caps2_ff[p];
                if (wr_port[p] && (bus_offset_i == OFS_CAPS)) begin
                    nxt_caps[p] = bus_wdata_i & CAPS_MASK; // RL15 RL16
                end
                if (wr_port[p] && (bus_offset_i == OFS_CAPS2)) begin
                    nxt_caps2[p] = bus_wdata_i;
                end
                // Back-channel load wins over a write in the same cycle for the four auto bits
                if (caps_load_i[p] && !caps_ff[p][BIT_HOLD_CAPS]) begin // RL13
                    nxt_caps[p] = (nxt_caps[p] & ~AUTO_CAPS_MASK) |
                                  {4'h0, caps_auto[p]}; // RL17
                end
            end

            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    caps_ff[p]  <= RST_CAPS;
                    caps2_ff[p] <= RST_CAPS2;
                end else begin
                    caps_ff[p]  <= nxt_caps[p];
                    caps2_ff[p] <= nxt_caps2[p];
                end
            end

            assign rate_training_tx_o[p]      = caps_ff[p][BIT_RATE_TRAIN]; // RL14
            assign equalizer_training_tx_o[p] = caps_ff[p][BIT_EQ_TRAIN]; // RL14
        end
    endgenerate

    // Read data, captured on the read strobe
    always_comb begin
        nxt_rdata = rdata_ff;
        if (dev_hit && bus_rd_i) begin
            case (bus_offset_i)
                OFS_PORT_STEER: nxt_rdata = {5'h00, steer_ff};
                OFS_PIX_RATE:   nxt_rdata = ctl.meas_count; // RL11
                OFS_CAPS:       nxt_rdata = rd_second ? caps_ff[1] : caps_ff[0]; // RL6
                OFS_CAPS2:      nxt_rdata = rd_second ? caps2_ff[1] : caps2_ff[0]; // RL4 RL5
                OFS_LINK_TMO:   nxt_rdata = {6'h00, tmo_ff};
                default:        nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign bus_rdata_o = rdata_ff;

    psfclc_freq_meter u_freq_meter (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .pix_clk_i (pix_clk_i),
        .ctl       (ctl.meter)
    );

    psfclc_link_timer u_link_timer (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .rev_valid_i (rev_valid_i),
        .ctl         (ctl.timer)
    );

endmodule : psfclc_port_regs

// ---- sim/psfclc_host_model.sv ----
// Host controller issuing single-byte register accesses
// Assumes the bus answers combinationally and read data follows a cycle later
`timescale 1ns/1ps
module psfclc_host_model (
    input  wire logic clock_i,
    input  wire logic bus_ack_i,
    output logic [6:0] bus_dev_addr_o,
    output logic [7:0] bus_offset_o,
    output logic       bus_wr_o,
    output logic       bus_rd_o,
    output logic [7:0] bus_wdata_o
);
    logic [7:0] exp_q[$];
    logic       ack_seen = 1'b0;
    initial begin
        bus_dev_addr_o = 7'h00;
        bus_offset_o = 8'h00;
        bus_wr_o = 1'b0;
        bus_rd_o = 1'b0;
        bus_wdata_o = 8'h00;
    end
    task automatic access(input logic [6:0] dev, input logic [7:0] ofs, input logic w,
                          input logic [7:0] d);
        @(posedge clock_i);
        #1;
        bus_dev_addr_o = dev;
        bus_offset_o = ofs;
        bus_wdata_o = d;
        bus_wr_o = w;
        bus_rd_o = !w;
        @(posedge clock_i);
        ack_seen = bus_ack_i;
        #1;
        bus_wr_o = 1'b0;
        bus_rd_o = 1'b0;
        bus_wdata_o = ~d;
    endtask : access
    task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d);
        access(dev, ofs, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] e);
        exp_q.push_back(e);
        access(dev, ofs, 1'b0, 8'h00);
    endtask : rd
    // Second address is switched on before mirrored remote traffic that must be answered
    task automatic enable_second(input logic [6:0] dev, input logic [7:0] d);
        wr(dev, 8'h1E, d | 8'h04);
    endtask : enable_second
    // Caps overwritten through this task go out with the freeze bit
    task automatic write_frozen(input logic [6:0] dev, input logic [7:0] d);
        wr(dev, 8'h20, d | 8'h80);
    endtask : write_frozen
endmodule : psfclc_host_model

// ---- sim/psfclc_port_regs_monitor.sv ----
// Checker for bus answers, read hold, link detect and steering outputs
// Assumes it is bound onto psfclc_port_regs on its single oscillator clock
`timescale 1ns/1ps
module psfclc_port_regs_monitor
    import psfclc_pkg::*;
#(
    parameter logic [6:0] PRIMARY_ADDR = 7'h2C, // Arbitrary value
    parameter int         TMO_1300_CYC = 26000
) (
    input wire logic       clock_i,
    input wire logic       rst_i,
    input wire logic [6:0] bus_dev_addr_i,
    input wire logic [7:0] bus_offset_i,
    input wire logic       bus_wr_i,
    input wire logic       bus_rd_i,
    input wire logic       bus_ack_o,
    input wire logic [7:0] bus_rdata_o,
    input wire logic       rev_valid_i,
    input wire logic       link_detect_o,
    input wire logic [1:0] rate_training_tx_o,
    input wire logic [1:0] equalizer_training_tx_o,
    input wire logic       io_ctrl_second_link_o
);
    localparam int MAX_T = (TMO_1300_CYC > TMO_162_CYC) ? TMO_1300_CYC : TMO_162_CYC;
    logic [15:0] since_ff;
    logic [15:0] nxt_since;
    logic        hit_wr;
    logic        strobe;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    assign hit_wr = bus_wr_i && bus_ack_o;
    assign strobe = bus_wr_i || bus_rd_i;
    // Cycles since the last reverse-channel pulse
    always_comb begin
        nxt_since = since_ff;
        if (rev_valid_i) nxt_since = 16'h0000;
        else if (since_ff != 16'hFFFF) nxt_since = since_ff + 16'h0001;
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) since_ff <= 16'hFFFF;
        else since_ff <= nxt_since;
    end
    property p_ack_strobe; bus_ack_o |-> strobe; endproperty
    property p_ack_primary; strobe && bus_dev_addr_i == PRIMARY_ADDR |-> bus_ack_o; endproperty
    property p_ack_foreign;
        strobe && bus_dev_addr_i != PRIMARY_ADDR && bus_dev_addr_i != PRIMARY_ADDR + 7'h01
        |-> !bus_ack_o;
    endproperty
    property p_rdata_hold; !$past(bus_rd_i && bus_ack_o) |-> $stable(bus_rdata_o); endproperty
    property p_link_rise; rev_valid_i |=> link_detect_o [*8]; endproperty
    property p_link_cause; $rose(link_detect_o) |-> $past(rev_valid_i); endproperty
    property p_link_bound; link_detect_o |-> since_ff < MAX_T; endproperty
    property p_io_cause;
        $changed(io_ctrl_second_link_o) |-> $past(hit_wr && bus_offset_i == OFS_PORT_STEER);
    endproperty
    property p_train_cause;
        $changed({rate_training_tx_o, equalizer_training_tx_o})
        |-> $past(hit_wr && bus_offset_i == OFS_CAPS);
    endproperty
    a_ack_strobe: assert property (p_ack_strobe) else $error("ack without strobe");
    a_ack_primary: assert property (p_ack_primary) else $error("primary not answered");
    a_ack_foreign: assert property (p_ack_foreign) else $error("foreign answered");
    a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
    a_link_rise: assert property (p_link_rise) else $error("link detect not held");
    a_link_cause: assert property (p_link_cause) else $error("link rose unprompted");
    a_link_bound: assert property (p_link_bound) else $error("link outlived timeout");
    a_io_cause: assert property (p_io_cause) else $error("io steer moved");
    a_train_cause: assert property (p_train_cause) else $error("training moved");
    c_second: cover property (strobe && bus_ack_o && bus_dev_addr_i == PRIMARY_ADDR + 7'h01);
    c_link_fall: cover property ($fell(link_detect_o));
    c_io_rise: cover property ($rose(io_ctrl_second_link_o));
endmodule : psfclc_port_regs_monitor

bind psfclc_port_regs psfclc_port_regs_monitor #(
    .PRIMARY_ADDR(PRIMARY_ADDR),
    .TMO_1300_CYC(TMO_1300_CYC)
) u_monitor (
    .clock_i(clock_i), .rst_i(rst_i), .bus_dev_addr_i(bus_dev_addr_i),
    .bus_offset_i(bus_offset_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
    .bus_ack_o(bus_ack_o), .bus_rdata_o(bus_rdata_o), .rev_valid_i(rev_valid_i),
    .link_detect_o(link_detect_o), .rate_training_tx_o(rate_training_tx_o),
    .equalizer_training_tx_o(equalizer_training_tx_o),
    .io_ctrl_second_link_o(io_ctrl_second_link_o)
);

// ---- sim/tb_psfclc_port_regs.sv ----
// Self-checking bench for port steering, pixel rate, caps and link timeout
// Assumes the host model owns the register port and the bench drives the rest
`timescale 1ns/1ps
module tb_psfclc_port_regs;
    import psfclc_pkg::*;
    localparam logic [6:0] PA = 7'h2C; // Arbitrary value
    localparam logic [6:0] PB = PA + 7'h01;
    logic       clock_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       pix_clk_i = 1'b0;
    logic       rev_valid_i = 1'b0;
    logic [1:0] caps_load_i = 2'b00;
    logic [3:0] caps_auto_p0_i = 4'h0;
    logic [3:0] caps_auto_p1_i = 4'h0;
    logic [6:0] bus_dev_addr_i;
    logic [7:0] bus_offset_i, bus_wdata_i, bus_rdata_o, e;
    logic       bus_wr_i, bus_rd_i, bus_ack_o, link_detect_o, io_ctrl_second_link_o;
    logic [1:0] rate_training_tx_o, equalizer_training_tx_o;
    logic       rd_seen = 1'b0;
    logic [31:0] rs = 32'h5FF0AFB6;
    int n_fail = 0, comparisons = 0, cycles = 0, cnt;
    int tmo_t[4] = '{20, TMO_162_CYC, 40, 80};
    logic [7:0] ofs_t[6] = '{OFS_PORT_STEER, OFS_PIX_RATE, OFS_CAPS, OFS_CAPS2, OFS_LINK_TMO, 8'h30};
    logic [7:0] rst_t[6] = '{RST_PORT_STEER, RST_PIX_RATE, RST_CAPS, RST_CAPS2, RST_LINK_TMO, 8'h00};
    psfclc_port_regs #(.PRIMARY_ADDR(PA), .TMO_325_CYC(20), .TMO_650_CYC(40), .TMO_1300_CYC(80))
    DUT (.clock_i(clock_i), .rst_i(rst_i), .bus_dev_addr_i(bus_dev_addr_i),
         .bus_offset_i(bus_offset_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
         .bus_wdata_i(bus_wdata_i), .bus_ack_o(bus_ack_o), .bus_rdata_o(bus_rdata_o),
         .pix_clk_i(pix_clk_i), .rev_valid_i(rev_valid_i), .link_detect_o(link_detect_o),
         .caps_load_i(caps_load_i), .caps_auto_p0_i(caps_auto_p0_i),
         .caps_auto_p1_i(caps_auto_p1_i), .rate_training_tx_o(rate_training_tx_o),
         .equalizer_training_tx_o(equalizer_training_tx_o),
         .io_ctrl_second_link_o(io_ctrl_second_link_o));
    psfclc_host_model host (.clock_i(clock_i), .bus_ack_i(bus_ack_o),
         .bus_dev_addr_o(bus_dev_addr_i), .bus_offset_o(bus_offset_i), .bus_wr_o(bus_wr_i),
         .bus_rd_o(bus_rd_i), .bus_wdata_o(bus_wdata_i));
    initial begin
        forever #25 clock_i = ~clock_i;
    end
    initial begin
        #37;
        forever #100 pix_clk_i = ~pix_clk_i;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic chk(input string what, input logic [15:0] ex, input logic [15:0] got);
        comparisons++;
        if (got !== ex) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, ex, got);
        end
    endtask : chk
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : tick
    task automatic pulse_rev;
        rev_valid_i = 1'b1;
        tick(1);
        rev_valid_i = 1'b0;
    endtask : pulse_rev
    always @(posedge clock_i) begin
        rd_seen <= bus_rd_i & bus_ack_o;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            summarize();
        end
    end
    // Each read result is taken against the oldest expectation
    always @(negedge clock_i) begin
        if (rd_seen === 1'b1) begin
            e = (host.exp_q.size() > 0) ? host.exp_q.pop_front() : 8'hXX;
            chk("bus_rdata_o", e, bus_rdata_o);
        end
    end
    initial begin
        tick(20);
        rst_i = 1'b0;
        foreach (ofs_t[i]) host.rd(PA, ofs_t[i], rst_t[i]);
        $display("test reset_values done");
        host.wr(PA, OFS_CAPS, 8'h30);
        tick(1);
        chk("rate_training_tx_o", 2'b01, rate_training_tx_o);
        chk("equalizer_training_tx_o", 2'b01, equalizer_training_tx_o);
        rs = xs(rs);
        host.wr(PA, OFS_PORT_STEER, 8'h03);
        host.wr(PA, OFS_CAPS2, rs[7:0]);
        host.rd(PA, OFS_CAPS, 8'h00);
        host.wr(PA, OFS_PORT_STEER, 8'h02);
        chk("io_ctrl_second_link_o", 1'b1, io_ctrl_second_link_o);
        host.rd(PA, OFS_CAPS2, rs[7:0]);
        host.wr(PA, OFS_PORT_STEER, 8'h01);
        host.rd(PA, OFS_CAPS, 8'h30);
        host.rd(PA, OFS_CAPS2, rs[7:0]);
        $display("test steering done");
        host.access(PB, OFS_CAPS, 1'b1, 8'h10);
        chk("bus_ack_o", 1'b0, host.ack_seen);
        tick(1);
        chk("equalizer_training_tx_o", 2'b01, equalizer_training_tx_o);
        host.enable_second(PA, 8'h02);
        chk("io_ctrl_second_link_o", 1'b0, io_ctrl_second_link_o);
        host.rd(PA, OFS_CAPS, 8'h30);
        host.wr(PB, OFS_CAPS, 8'h20);
        tick(1);
        chk("rate_training_tx_o", 2'b11, rate_training_tx_o);
        host.rd(PB, OFS_PORT_STEER, 8'h06);
        host.access(PA + 7'h02, OFS_CAPS, 1'b0, 8'h00);
        chk("bus_ack_o", 1'b0, host.ack_seen);
        $display("test second_address done");
        rs = xs(rs);
        caps_auto_p0_i = rs[3:0];
        caps_auto_p1_i = rs[7:4];
        caps_load_i = 2'b11;
        tick(1);
        caps_load_i = 2'b00;
        host.rd(PA, OFS_CAPS, {4'h3, rs[3:0]});
        host.rd(PB, OFS_CAPS, {4'h2, rs[7:4]});
        host.write_frozen(PA, 8'h35);
        caps_auto_p0_i = ~rs[3:0];
        caps_load_i = 2'b01;
        tick(1);
        caps_load_i = 2'b00;
        host.rd(PA, OFS_CAPS, 8'hB5);
        $display("test caps done");
        host.wr(PA, OFS_PIX_RATE, 8'd200);
        tick(208);
        host.rd(PA, OFS_PIX_RATE, 8'd50);
        host.wr(PA, OFS_PIX_RATE, 8'd0);
        tick(8);
        host.rd(PA, OFS_PIX_RATE, 8'd0);
        host.wr(PA, OFS_PIX_RATE, 8'd200);
        tick(40);
        host.wr(PA, OFS_PIX_RATE, 8'd40);
        tick(48);
        host.rd(PA, OFS_PIX_RATE, 8'd10);
        $display("test pixel_rate done");
        for (int i = 0; i < 4; i++) begin
            host.wr(PA, OFS_LINK_TMO, 8'(i));
            host.rd(PA, OFS_LINK_TMO, 8'(i));
            pulse_rev();
            tick(5);
            pulse_rev();
            cnt = 0;
            while (link_detect_o === 1'b1 && cnt < 4000) begin
                tick(1);
                cnt++;
            end
            chk("link_detect_o hold", 16'(tmo_t[i]), 16'(cnt));
        end
        $display("test link_timeout done");
        rst_i = 1'b1;
        tick(2);
        rst_i = 1'b0;
        host.rd(PA, OFS_PORT_STEER, RST_PORT_STEER);
        host.rd(PA, OFS_CAPS, RST_CAPS);
        chk("rate_training_tx_o", 2'b00, rate_training_tx_o);
        chk("link_detect_o", 1'b0, link_detect_o);
        $display("test mid_reset done");
        tick(4);
        chk("pending reads", 16'h0000, 16'(host.exp_q.size()));
        summarize();
    end
endmodule : tb_psfclc_port_regs
